// [baseband_model.sv]
// Baseband controller model: conversion clock and shared-line level.
// Assumes its inputs change on the falling edge of the core clock.
`timescale 1ns/10ps
module baseband_model (
    input  wire logic       core_clk_i,
    input  wire logic       drive_i,
    input  wire logic [4:0] word_i,
    input  wire logic [4:0] dev_data_i,
    input  wire logic [4:0] dev_oe_n_i,
    output logic            conv_clk_o,
    output logic [4:0]      wire_o
);
    logic [1:0] phase = 2'h0;
    initial conv_clk_o = 1'b0;
    // One eighth of the core rate, always off the core sampling edge
    always @(negedge core_clk_i) begin
        phase <= phase + 2'h1;
        if (phase == 2'h3) begin
            conv_clk_o <= ~conv_clk_o;
        end
    end
    // Contention shows as unknown; idle lines are held low, never high
    always_comb begin
        for (int b = 0; b < 5; b++) begin
            if (!dev_oe_n_i[b] && drive_i) wire_o[b] = 1'bx;
            else if (!dev_oe_n_i[b]) wire_o[b] = dev_data_i[b];
            else if (drive_i) wire_o[b] = word_i[b];
            else wire_o[b] = 1'b0;
        end
    end
endmodule : baseband_model

// [converter_pkg.sv]
// Shared constants and types for the converter parallel-port control logic.
// Assumes a single 20 MHz core clock and a synchronous active-low reset.
package converter_pkg;

    localparam int ADC_WIDTH  = 5;
    localparam int DAC_WIDTH  = 7;
    localparam int HIGH_WIDTH = DAC_WIDTH - ADC_WIDTH;

    // Two's complement codes; zero means mid-scale for both converters
    localparam logic [ADC_WIDTH-1:0] ADC_ZERO = 5'h00;
    localparam logic [DAC_WIDTH-1:0] DAC_ZERO = 7'h00;
    localparam logic [DAC_WIDTH-1:0] DAC_POS_FULL = 7'h3f;
    localparam logic [DAC_WIDTH-1:0] DAC_NEG_FULL = 7'h40;

    // Output enables are active low; all ones releases the shared lines
    localparam logic [ADC_WIDTH-1:0] LINES_DRIVEN   = 5'h00;
    localparam logic [ADC_WIDTH-1:0] LINES_RELEASED = 5'h1f;

    // Wake-up from shutdown; a longest time, so the count rounds down
    localparam int CLK_PERIOD_PS = 50000;
    localparam int WAKE_TIME_PS  = 2400000;
    localparam int WAKE_CYCLES   = WAKE_TIME_PS / CLK_PERIOD_PS;
    localparam int WAKE_WIDTH    = $clog2(WAKE_CYCLES + 1);
    localparam logic [WAKE_WIDTH-1:0] WAKE_LAST = WAKE_WIDTH'(WAKE_CYCLES - 1);
    localparam logic [WAKE_WIDTH-1:0] WAKE_CLEAR = '0;
    localparam logic [WAKE_WIDTH-1:0] WAKE_STEP  = WAKE_WIDTH'(1);

    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'h0,
        MODE_TRANSMIT = 2'h1,
        MODE_RECEIVE  = 2'h2
    } mode_type;

endpackage : converter_pkg

// [tb_txrx_converter_parallel_port.sv]
// Self-checking bench for the converter parallel-port block.
// Assumes the baseband model makes the conversion clock.
`timescale 1ns/10ps
module tb_txrx_converter_parallel_port;
    import converter_pkg::*;
    logic       core_clk_i, reset_n_i, rx_sel, tx_sel, six, five, drive;
    logic [4:0] adc_code, word, dev_data, oe_n, line;
    logic [6:0] dac_code;
    logic       conv_clk, adc_en, dac_en, ready;
    logic [6:0] tx_tab [4] = '{DAC_POS_FULL, DAC_NEG_FULL, DAC_ZERO, 7'h55};
    logic [4:0] rx_tab [4] = '{5'h0f, 5'h10, 5'h1f, 5'h0a};
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cycles = 0;
    txrx_converter_parallel_port i_txrx_converter_parallel_port (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .receive_select_i(rx_sel),
        .transmit_select_i(tx_sel), .conv_clk_i(conv_clk), .dac_bit_six_i(six),
        .dac_bit_five_i(five), .shared_data_i(line), .adc_code_i(adc_code),
        .shared_data_o(dev_data), .shared_data_oe_n_o(oe_n), .dac_code_o(dac_code),
        .adc_enable_o(adc_en), .dac_enable_o(dac_en), .ready_o(ready));
    baseband_model i_baseband_model (
        .core_clk_i(core_clk_i), .drive_i(drive), .word_i(word), .dev_data_i(dev_data),
        .dev_oe_n_i(oe_n), .conv_clk_o(conv_clk), .wire_o(line));
    ////////////////////////////////////////////////////////////////////////////////
    task summarize();
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task chk(input logic [6:0] got, input logic [6:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Our lines are released before the mode flips, taken only after it settles
    task set_mode(input logic rx, input logic tx);
        @(negedge core_clk_i);
        drive = 1'b0;
        rx_sel = rx;
        tx_sel = tx;
        repeat (2) @(negedge core_clk_i);
        drive = tx & ~rx;
    endtask : set_mode
    ////////////////////////////////////////////////////////////////////////////////
    task t_modes();
        for (int i = 0; i < 4; i++) begin
            set_mode(i[1], i[0]);
            chk({adc_en, dac_en}, {i == 2, i == 1});
            chk(oe_n, (i == 2) ? LINES_DRIVEN : LINES_RELEASED);
        end
    endtask : t_modes
    task t_wake();
        int n;
        n = 0;
        @(negedge core_clk_i);
        rx_sel = 1'b1;
        tx_sel = 1'b0;
        while (ready !== 1'b1 && n < 60) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(n <= WAKE_CYCLES, 1);
        set_mode(1'b0, 1'b1);
        chk(ready, 0);
    endtask : t_wake
    task t_transmit();
        for (int i = 0; i < 4; i++) begin
            {six, five, word} = tx_tab[i];
            @(negedge conv_clk);
            repeat (2) @(negedge core_clk_i);
            chk(dac_code, (i == 0) ? DAC_ZERO : tx_tab[i-1]);
            @(posedge conv_clk);
            repeat (3) @(negedge core_clk_i);
            chk(dac_code, tx_tab[i]);
        end
    endtask : t_transmit
    // Code changes right after the sampling edge, so only the sampled one may appear
    task t_receive();
        set_mode(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            adc_code = rx_tab[i];
            @(negedge conv_clk);
            @(negedge core_clk_i);
            adc_code = ~rx_tab[i];
            if (i > 0) chk(dev_data, rx_tab[i-1]);
            @(posedge conv_clk);
            repeat (3) @(negedge core_clk_i);
            chk(dev_data, rx_tab[i]);
            chk(line, rx_tab[i]);
        end
    endtask : t_receive
    task t_shutdown();
        set_mode(1'b1, 1'b1);
        {six, five, word} = 7'h2a;
        repeat (24) @(negedge core_clk_i);
        chk(dev_data, rx_tab[3]);
        chk(dac_code, tx_tab[3]);
        chk({adc_en, dac_en, line}, 0);
    endtask : t_shutdown
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        {reset_n_i, rx_sel, tx_sel, six, five, drive, adc_code, word} = '0;
        repeat (2) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        chk({oe_n, ready, adc_en}, {LINES_RELEASED, 2'h0});
        t_modes();
        t_wake();
        t_transmit();
        t_receive();
        t_shutdown();
        summarize();
    end
endmodule : tb_txrx_converter_parallel_port

// [txrx_converter_parallel_port.sv]
// Digital side of a combined 5-bit receive / 7-bit transmit converter
// sharing one parallel data port, with mode selects and a sampled
// conversion clock.
// Assumes all inputs, the conversion clock among them, are synchronous
// to core_clk_i, and that the conversion clock is well below 10 MHz.
// Limitation: ready_o is advisory; conversions run while it is still low.
//
// Functional notes
// - Receive select high with transmit select low enables only the receive converter.
// - Transmit select high with receive select low enables only the transmit converter.
// - Equal select levels put the block in shutdown with both converters off.
// - The two dedicated inputs form the top two transmit bits, bit six the most significant.
// - In transmit mode the shared lines supply the low five transmit bits, line zero the LSB.
// - In receive mode the shared lines are driven with the 5-bit result, line four the MSB.
// - In receive mode a sample is taken on the falling conversion clock edge.
// - In receive mode the shared output lines change only on rising conversion clock edges.
// - In transmit mode the word is captured on the falling edge; the far side holds it there.
// - In transmit mode the captured word reaches the converter on the next rising edge.
// - In shutdown the conversion clock may run and leaves the captured and output words untouched.
// - The transmit word is two's complement, 3f positive full scale, 40 negative full scale.
// - The receive result is presented in two's complement.
// - After leaving shutdown the block reports ready within 2.4 us.
`timescale 1ns/10ps
module txrx_converter_parallel_port (
    input  wire logic                                core_clk_i,
    input  wire logic                                reset_n_i,
    input  wire logic                                receive_select_i,
    input  wire logic                                transmit_select_i,
    input  wire logic                                conv_clk_i,
    input  wire logic                                dac_bit_six_i,
    input  wire logic                                dac_bit_five_i,
    input  wire logic [converter_pkg::ADC_WIDTH-1:0] shared_data_i,
    input  wire logic [converter_pkg::ADC_WIDTH-1:0] adc_code_i,
    output logic      [converter_pkg::ADC_WIDTH-1:0] shared_data_o,
    output logic      [converter_pkg::ADC_WIDTH-1:0] shared_data_oe_n_o,
    output logic      [converter_pkg::DAC_WIDTH-1:0] dac_code_o,
    output logic                                     adc_enable_o,
    output logic                                     dac_enable_o,
    output logic                                     ready_o
);
    import converter_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    mode_type next_mode;
    mode_type mode;

    always_comb begin
        unique case ({receive_select_i, transmit_select_i})
            2'h2:    next_mode = MODE_RECEIVE;
            2'h1:    next_mode = MODE_TRANSMIT;
            2'h0,
            2'h3:    next_mode = MODE_SHUTDOWN;
        endcase
    end

    wire rx_now     = (next_mode == MODE_RECEIVE);
    wire tx_now     = (next_mode == MODE_TRANSMIT);
    wire active_now = rx_now || tx_now;
    wire mode_start = active_now && (next_mode != mode);

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock edges, seen as a sampled level

    // Edge seen between two samples; only one core cycle of history is kept
    function automatic logic level_edge(
        input logic prev_level,
        input logic now_level,
        input logic rising
    );
        level_edge = rising ? (!prev_level && now_level) : (prev_level && !now_level);
    endfunction : level_edge

    logic conv_clk_prev;
    wire  clk_fall = level_edge(conv_clk_prev, conv_clk_i, 1'b0);
    wire  clk_rise = level_edge(conv_clk_prev, conv_clk_i, 1'b1);

    ////////////////////////////////////////////////////////////////////////
    // Data path: master stage on falling edge, slave stage on rising edge

    logic [ADC_WIDTH-1:0] adc_sample;
    logic [DAC_WIDTH-1:0] dac_hold;

    // Two's complement passes through untouched on both paths
    wire [DAC_WIDTH-1:0] tx_word =
        {dac_bit_six_i, dac_bit_five_i, shared_data_i};
    wire capture_rx = rx_now && clk_fall;
    wire capture_tx = tx_now && clk_fall;
    wire update_rx  = rx_now && clk_rise;
    wire update_tx  = tx_now && clk_rise;
    wire [ADC_WIDTH-1:0] next_oe_n = rx_now ? LINES_DRIVEN : LINES_RELEASED;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mode               <= MODE_SHUTDOWN;
            conv_clk_prev      <= 1'b0;
            adc_enable_o       <= 1'b0;
            dac_enable_o       <= 1'b0;
            shared_data_oe_n_o <= LINES_RELEASED;
        end else begin
            mode               <= next_mode;
            conv_clk_prev      <= conv_clk_i;
            adc_enable_o       <= rx_now;
            dac_enable_o       <= tx_now;
            shared_data_oe_n_o <= next_oe_n;
        end
    end

    // Shutdown leaves these alone, so a running clock changes nothing
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            adc_sample    <= ADC_ZERO;
            dac_hold      <= DAC_ZERO;
            shared_data_o <= ADC_ZERO;
            dac_code_o    <= DAC_ZERO;
        end else begin
            if (capture_rx) adc_sample <= adc_code_i;
            if (capture_tx) dac_hold <= tx_word;
            if (update_rx) shared_data_o <= adc_sample;
            if (update_tx) dac_code_o <= dac_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up settle time

    wake_timer u_wake_timer (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .restart_i  (mode_start),
        .active_i   (active_now),
        .ready_o    (ready_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Ready shows at the sample after the last settle edge
    localparam int WAKE_BOUND = WAKE_CYCLES - 1;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Checker-side age of the current active mode, saturating at the wake bound
    logic [WAKE_WIDTH-1:0] wake_age;
    wire                   wake_age_full = (wake_age == WAKE_LAST);

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || mode_start || !active_now) begin
            wake_age <= WAKE_CLEAR;
        end else if (!wake_age_full) begin
            wake_age <= wake_age + WAKE_STEP;
        end
    end

    a_rx_mode_decode: assert property (
        receive_select_i && !transmit_select_i |=> adc_enable_o && !dac_enable_o)
        else $error("receive mode not decoded");
    a_tx_mode_decode: assert property (
        transmit_select_i && !receive_select_i |=> dac_enable_o && !adc_enable_o)
        else $error("transmit mode not decoded");
    a_shutdown_both_off: assert property (
        receive_select_i == transmit_select_i |=> !adc_enable_o && !dac_enable_o)
        else $error("converter enabled in shutdown");
    a_tx_word_order: assert property (
        capture_tx |=> dac_hold == {$past(dac_bit_six_i), $past(dac_bit_five_i),
                                    $past(shared_data_i)})
        else $error("transmit word bits misplaced");
    a_rx_lines_driven: assert property (
        shared_data_oe_n_o == (adc_enable_o ? LINES_DRIVEN : LINES_RELEASED))
        else $error("shared line direction wrong");
    a_tx_lines_free: assert property (
        dac_enable_o |-> shared_data_oe_n_o == LINES_RELEASED)
        else $error("shared lines driven in transmit mode");
    a_rx_sample_fall: assert property (
        capture_rx |=> adc_sample == $past(adc_code_i))
        else $error("sample not taken on falling edge");
    a_rx_sample_hold: assert property (
        !capture_rx |=> $stable(adc_sample))
        else $error("sample changed off a falling edge");
    a_rx_out_source: assert property (
        update_rx |=> shared_data_o == $past(adc_sample))
        else $error("output lines do not carry the sample");
    a_rx_out_rise: assert property (
        !$stable(shared_data_o) |-> $past(update_rx))
        else $error("output lines changed off a rising edge");
    a_tx_update_chain: assert property (
        update_tx |=> dac_code_o == $past(dac_hold))
        else $error("captured word not applied on rising edge");
    a_tx_out_rise: assert property (
        !$stable(dac_code_o) |-> $past(update_tx))
        else $error("converter word changed off a rising edge");
    a_dac_frozen_rx: assert property (
        rx_now |=> $stable(dac_code_o) && $stable(dac_hold))
        else $error("transmit path moved in receive mode");
    a_adc_frozen_tx: assert property (
        tx_now |=> $stable(shared_data_o) && $stable(adc_sample))
        else $error("receive path moved in transmit mode");
    a_shutdown_frozen: assert property (
        next_mode == MODE_SHUTDOWN |=> $stable(dac_code_o) && $stable(shared_data_o)
                                       && $stable(dac_hold) && $stable(adc_sample))
        else $error("state changed in shutdown");
    a_wake_bound: assert property (
        mode_start ##1 active_now[*1] |-> ##[0:WAKE_BOUND] (ready_o || !active_now || mode_start))
        else $error("not ready within wake time");
    a_wake_held: assert property (
        wake_age_full && active_now && !mode_start |-> ready_o)
        else $error("ready missing after wake time");
    a_ready_drops: assert property (
        !active_now |=> !ready_o)
        else $error("ready held in shutdown");

    c_rx_word:  cover property (update_rx ##1 !shared_data_oe_n_o[0]);
    c_tx_full:  cover property (update_tx ##1 dac_code_o == DAC_NEG_FULL);
    c_tx_pos:   cover property (update_tx ##1 dac_code_o == DAC_POS_FULL);
    c_wake:     cover property (mode_start ##1 !ready_o ##[1:WAKE_BOUND] ready_o);
    c_sd_clk:   cover property (next_mode == MODE_SHUTDOWN && clk_rise);

endmodule : txrx_converter_parallel_port

// [wake_timer.sv]
// Wake-up timer: counts the settle time after a converter is enabled.
// Assumes restart_i pulses in the cycle a new active mode is selected.
`timescale 1ns/10ps
module wake_timer (
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic restart_i,
    input  wire logic active_i,
    output logic      ready_o
);
    import converter_pkg::*;

    logic [WAKE_WIDTH-1:0] count;
    wire                   count_done = (count == WAKE_LAST);
    wire                   idle       = !reset_n_i || !active_i;

    // A restart loads one: the restart edge is already the first settle cycle,
    // which keeps the flag inside the wake bound measured from the select change
    always_ff @(posedge core_clk_i) begin
        if (idle) begin
            count   <= WAKE_CLEAR;
            ready_o <= 1'b0;
        end else if (restart_i) begin
            count   <= WAKE_STEP;
            ready_o <= 1'b0;
        end else if (count_done) begin
            ready_o <= 1'b1;
        end else begin
            count   <= count + WAKE_STEP;
        end
    end

endmodule : wake_timer
